// file: common/btc_pkg.sv
// Functional notes
// [R1] Retry limit is a 32-bit writable word, reset value 0100_0000h.
// [R2] Default retry limit makes the retry interval 2^24 clocks before timeout.
// [R3] Upstream master timeout in bits 15:0, reset 8000h, fires after 2^15 clocks.
// [R4] Downstream master timeout in bits 31:16, reset 8000h, fires after 2^15 clocks.
// [R5] Slot entry capability code reads 04h, read-only.
// [R6] Slot entry link bits 15:8 read 00h for the listed strap combinations.
// [R7] Slot number 20:16, first-in-chassis 21, chassis 31:24 writable, reset zero.
// [R8] Slot word bits 23:22 are reserved and read zero.
// [R9] Power entry capability code reads 01h in bits 7:0.
// [R10] Power entry link bits 15:8 read 0Bh.
// [R11] Power revision field bits 18:16 reads 001.
// [R12] Unsupported capability bits and reserved bits 24:22 read zero.
// [R13] Power state bits 1:0 writable, 00 is D0, 11 is D3, reset zero.
// [R14] Writing an unimplemented power state is accepted but leaves the field unchanged.
// [R15] Writing D0 while in D3 pulses internal chip reset, no downstream reset.
// [R16] Power control bits 15:8 read zero.
// [R17] Third entry code bits 7:0 uses encoding up to 06h, hot swap.
// [R18] Third entry link bits 15:8 reads 00h, ending the list.
// [R19] Software programs nonzero limits before enabling forwarding.
// [R20] With hold option set, upstream request held until nothing pending or terminated.
`default_nettype none
package btc_pkg;
	localparam logic [7:0] OFS_RETRY = 8'h78;
	localparam logic [7:0] OFS_TIMEOUT = 8'h80;
	localparam logic [7:0] OFS_SLOT = 8'hb0;
	localparam logic [7:0] OFS_POWER_CAP = 8'hdc;
	localparam logic [7:0] OFS_POWER_CTL = 8'he0;
	localparam logic [7:0] OFS_THIRD = 8'he4;
	localparam logic [31:0] RETRY_RESET = 32'h0100_0000;
	localparam logic [15:0] TIMEOUT_RESET = 16'h8000;
	localparam logic [7:0] SLOT_CODE = 8'h04;
	localparam logic [7:0] POWER_CODE = 8'h01;
	localparam logic [7:0] POWER_LINK = 8'h0b;
	localparam logic [2:0] POWER_REVISION = 3'h1;
	localparam logic [7:0] HOT_SWAP_CODE = 8'h06;
	localparam logic [7:0] END_LINK = 8'h00;
	localparam logic [1:0] STATE_D0 = 2'h0;
	localparam logic [1:0] STATE_D3 = 2'h3;
	localparam int SLOT_NUM_LSB = 16;
	localparam int FIRST_CHASSIS_BIT = 21;
	localparam int CHASSIS_LSB = 24;
	localparam int LINK_LSB = 8;
	localparam int REVISION_LSB = 16;
	localparam int TIMER_COUNT = 3;
endpackage : btc_pkg
`default_nettype wire

// file: rtl/btc_regs.sv
`timescale 1ns/1ns
`default_nettype none
module btc_regs #(
	parameter logic [31:0] RETRY_LIMIT_RESET = btc_pkg::RETRY_RESET,
	parameter logic [15:0] UP_TIMEOUT_RESET = btc_pkg::TIMEOUT_RESET,
	parameter logic [15:0] DOWN_TIMEOUT_RESET = btc_pkg::TIMEOUT_RESET,
	parameter logic [7:0] SLOT_LINK_OTHER = 8'hdc,
	parameter logic [7:0] THIRD_CODE = btc_pkg::HOT_SWAP_CODE
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic strap_select_low,
	input wire logic strap_select_high,
	input wire logic retry_active,
	input wire logic up_master_active,
	input wire logic down_master_active,
	output logic retry_timeout,
	output logic up_master_timeout,
	output logic down_master_timeout,
	input wire logic up_hold_request_longer,
	input wire logic up_request_pending,
	input wire logic up_frame_start,
	input wire logic up_target_terminate,
	output logic up_bus_request,
	output logic internal_chip_reset
);
	logic [31:0] retry_limit;
	logic [15:0] upstream_master_timeout;
	logic [15:0] downstream_master_timeout;
	logic [4:0] slot_number;
	logic first_in_chassis;
	logic [7:0] chassis_numbering;
	logic [1:0] power_state;
	logic [1:0] strap_meta;
	logic [1:0] strap_sync;
	logic [7:0] slot_cap_link;
	logic [31:0] next_rdata;
	logic [31:0] timer_limit [btc_pkg::TIMER_COUNT];
	logic [btc_pkg::TIMER_COUNT-1:0] timer_active;
	logic [btc_pkg::TIMER_COUNT-1:0] timer_fire;
	logic wr_retry;
	logic wr_timeout;
	logic wr_slot;
	logic wr_power;
	logic [1:0] new_state;
	logic state_ok;

	assign wr_retry = cfg_write && (cfg_addr == btc_pkg::OFS_RETRY);
	assign wr_timeout = cfg_write && (cfg_addr == btc_pkg::OFS_TIMEOUT);
	assign wr_slot = cfg_write && (cfg_addr == btc_pkg::OFS_SLOT);
	assign wr_power = cfg_write && (cfg_addr == btc_pkg::OFS_POWER_CTL) && cfg_byte_en[0];
	assign new_state = cfg_wdata[1:0];
	assign state_ok = (new_state == btc_pkg::STATE_D0) || (new_state == btc_pkg::STATE_D3);

	// Strap pins synchronised
	always_ff @(posedge mclk) begin
		if (srst) begin
			strap_meta <= 2'h0;
			strap_sync <= 2'h0;
		end else begin
			strap_meta <= {strap_select_high, strap_select_low};
			strap_sync <= strap_meta;
		end
	end

	// Slot entry link from straps
	always_comb begin
		if (strap_sync[0] || (!strap_sync[0] && strap_sync[1])) begin
			slot_cap_link = btc_pkg::END_LINK; // R6
		end else begin
			slot_cap_link = SLOT_LINK_OTHER;
		end
	end

	// Retry limit, byte-lane writes
	always_ff @(posedge mclk) begin
		if (srst) begin
			retry_limit <= RETRY_LIMIT_RESET; // R1
		end else if (wr_retry) begin
			for (int b = 0; b < 4; b++) begin
				if (cfg_byte_en[b]) begin
					retry_limit[8*b +: 8] <= cfg_wdata[8*b +: 8]; // R1
				end
			end
		end
	end

	// Master timeout limits
	always_ff @(posedge mclk) begin
		if (srst) begin
			upstream_master_timeout <= UP_TIMEOUT_RESET; // R3
			downstream_master_timeout <= DOWN_TIMEOUT_RESET; // R4
		end else if (wr_timeout) begin
			if (cfg_byte_en[0]) begin
				upstream_master_timeout[7:0] <= cfg_wdata[7:0]; // R3
			end
			if (cfg_byte_en[1]) begin
				upstream_master_timeout[15:8] <= cfg_wdata[15:8]; // R3
			end
			if (cfg_byte_en[2]) begin
				downstream_master_timeout[7:0] <= cfg_wdata[23:16]; // R4
			end
			if (cfg_byte_en[3]) begin
				downstream_master_timeout[15:8] <= cfg_wdata[31:24]; // R4
			end
		end
	end

	// Slot numbering fields
	always_ff @(posedge mclk) begin
		if (srst) begin
			slot_number <= 5'h0; // R7
			first_in_chassis <= 1'b0; // R7
			chassis_numbering <= 8'h00; // R7
		end else if (wr_slot) begin
			if (cfg_byte_en[2]) begin
				slot_number <= cfg_wdata[btc_pkg::SLOT_NUM_LSB +: 5]; // R7
				first_in_chassis <= cfg_wdata[btc_pkg::FIRST_CHASSIS_BIT]; // R7
			end
			if (cfg_byte_en[3]) begin
				chassis_numbering <= cfg_wdata[btc_pkg::CHASSIS_LSB +: 8]; // R7
			end
		end
	end

	// Power state field and chip reset pulse
	always_ff @(posedge mclk) begin
		if (srst) begin
			power_state <= btc_pkg::STATE_D0; // R13
		end else if (wr_power && state_ok) begin
			power_state <= new_state; // R13 R14
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			internal_chip_reset <= 1'b0;
		end else begin
			internal_chip_reset <= wr_power && (new_state == btc_pkg::STATE_D0)
				&& (power_state == btc_pkg::STATE_D3); // R15
		end
	end

	// Read data mux
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (cfg_addr)
			btc_pkg::OFS_RETRY: begin
				next_rdata = retry_limit;
			end
			btc_pkg::OFS_TIMEOUT: begin
				next_rdata = {downstream_master_timeout, upstream_master_timeout}; // R3 R4
			end
			btc_pkg::OFS_SLOT: begin
				next_rdata[7:0] = btc_pkg::SLOT_CODE; // R5
				next_rdata[btc_pkg::LINK_LSB +: 8] = slot_cap_link; // R6
				next_rdata[btc_pkg::SLOT_NUM_LSB +: 5] = slot_number;
				next_rdata[btc_pkg::FIRST_CHASSIS_BIT] = first_in_chassis;
				next_rdata[btc_pkg::CHASSIS_LSB +: 8] = chassis_numbering; // R8
			end
			btc_pkg::OFS_POWER_CAP: begin
				next_rdata[7:0] = btc_pkg::POWER_CODE; // R9
				next_rdata[btc_pkg::LINK_LSB +: 8] = btc_pkg::POWER_LINK; // R10
				next_rdata[btc_pkg::REVISION_LSB +: 3] = btc_pkg::POWER_REVISION; // R11 R12
			end
			btc_pkg::OFS_POWER_CTL: begin
				next_rdata[1:0] = power_state; // R13 R16
			end
			btc_pkg::OFS_THIRD: begin
				next_rdata[7:0] = THIRD_CODE; // R17
				next_rdata[btc_pkg::LINK_LSB +: 8] = btc_pkg::END_LINK; // R18
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_ack <= 1'b0;
		end else begin
			cfg_rdata <= cfg_read ? next_rdata : 32'h0000_0000;
			cfg_ack <= cfg_read || cfg_write;
		end
	end

	// Retry and master timeout timers
	assign timer_limit[0] = retry_limit; // R2
	assign timer_limit[1] = {16'h0000, upstream_master_timeout};
	assign timer_limit[2] = {16'h0000, downstream_master_timeout};
	assign timer_active = {down_master_active, up_master_active, retry_active};

	for (genvar t = 0; t < btc_pkg::TIMER_COUNT; t++) begin : g_timer
		logic [31:0] count;
		logic fire;
		always_ff @(posedge mclk) begin
			if (srst || internal_chip_reset || !timer_active[t]) begin
				count <= 32'h0000_0000;
				fire <= 1'b0;
			end else if (timer_limit[t] != 32'h0000_0000
				&& count == timer_limit[t] - 32'h0000_0001) begin
				count <= 32'h0000_0000;
				fire <= 1'b1; // R2 R3 R4
			end else begin
				count <= count + 32'h0000_0001;
				fire <= 1'b0;
			end
		end
		assign timer_fire[t] = fire;
	end

	assign retry_timeout = timer_fire[0];
	assign up_master_timeout = timer_fire[1];
	assign down_master_timeout = timer_fire[2];

	// Upstream bus request
	always_ff @(posedge mclk) begin
		if (srst || internal_chip_reset) begin
			up_bus_request <= 1'b0;
		end else if (!up_bus_request) begin
			up_bus_request <= up_request_pending;
		end else if (up_hold_request_longer) begin
			up_bus_request <= up_request_pending && !up_target_terminate; // R20
		end else begin
			up_bus_request <= !up_frame_start;
		end
	end
endmodule : btc_regs
`default_nettype wire

// file: test/btc_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module btc_regs_sva (
	input wire logic mclk,
	input wire logic srst,
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack,
	input wire logic retry_active,
	input wire logic down_master_active,
	input wire logic retry_timeout,
	input wire logic up_master_timeout,
	input wire logic down_master_timeout,
	input wire logic up_hold_request_longer,
	input wire logic up_request_pending,
	input wire logic up_target_terminate,
	input wire logic up_bus_request,
	input wire logic internal_chip_reset
);
	logic pm_write;
	logic in_d3;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	assign pm_write = cfg_write && cfg_addr == btc_pkg::OFS_POWER_CTL && cfg_byte_en[0];
	// Tracks D3 from accepted power state writes
	always_ff @(posedge mclk) begin
		if (srst || (pm_write && cfg_wdata[1:0] == 2'h0)) begin
			in_d3 <= 1'b0;
		end else if (pm_write && cfg_wdata[1:0] == 2'h3) begin
			in_d3 <= 1'b1;
		end
	end
	sequence s_request;
		cfg_write || cfg_read;
	endsequence
	sequence s_wake;
		pm_write && cfg_wdata[1:0] == 2'h0 && in_d3;
	endsequence
	a_ack_follows: assert property (s_request |=> cfg_ack) else $error("no ack");
	a_slot_rsvd: assert property (cfg_ack && $past(cfg_read && cfg_addr == 8'hb0)
		|-> cfg_rdata[23:22] == 2'h0) else $error("slot reserved bits set");
	a_pm_fixed: assert property (cfg_ack && $past(cfg_read && cfg_addr == 8'hdc)
		|-> cfg_rdata == 32'h0001_0b01) else $error("power cap word wrong");
	a_wake_reset: assert property (s_wake |=> internal_chip_reset ##1 !internal_chip_reset)
		else $error("no chip reset pulse");
	a_up_pulse: assert property (up_master_timeout |=> !up_master_timeout)
		else $error("upstream timeout not a pulse");
	a_down_cause: assert property (down_master_timeout |-> $past(down_master_active))
		else $error("downstream timeout while idle");
	a_retry_pulse: assert property (retry_timeout |-> $past(retry_active) ##1 !retry_timeout)
		else $error("retry timeout wrong");
	a_req_start: assert property ($rose(up_bus_request) |-> $past(up_request_pending))
		else $error("request without pending");
	a_req_hold: assert property (up_bus_request && up_hold_request_longer && up_request_pending
		&& !up_target_terminate && !internal_chip_reset |=> up_bus_request)
		else $error("request dropped");
endmodule : btc_regs_sva
bind btc_regs btc_regs_sva btc_regs_sva_i (.mclk, .srst, .cfg_write, .cfg_read, .cfg_addr,
	.cfg_byte_en, .cfg_wdata, .cfg_rdata, .cfg_ack, .retry_active, .down_master_active,
	.retry_timeout, .up_master_timeout, .down_master_timeout, .up_hold_request_longer,
	.up_request_pending, .up_target_terminate, .up_bus_request, .internal_chip_reset);
`default_nettype wire

// file: test/btc_host.sv
`timescale 1ns/1ns
`default_nettype none
module btc_host (
	input wire logic mclk,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack,
	output logic cfg_write = 1'b0,
	output logic cfg_read = 1'b0,
	output logic [7:0] cfg_addr = 8'h00,
	output logic [3:0] cfg_byte_en = 4'h0,
	output logic [31:0] cfg_wdata = 32'h0000_0000
);
	// One request pulse, answer sampled one cycle later
	task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge mclk);
		cfg_write <= wr;
		cfg_read <= !wr;
		cfg_addr <= a;
		cfg_byte_en <= be;
		cfg_wdata <= d;
		@(posedge mclk);
		cfg_write <= 1'b0;
		cfg_read <= 1'b0;
		cfg_addr <= ~a;
		cfg_wdata <= ~d;
		#1;
		rd = cfg_ack ? cfg_rdata : 'x;
	endtask : access
endmodule : btc_host
`default_nettype wire

// file: test/btc_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module btc_regs_tb;
	typedef struct packed {logic w; logic [7:0] a; logic [3:0] b; logic [31:0] d;
		logic [31:0] e;} btc_row_type;
	logic mclk = 0, srst = 1, sl = 1, sh = 0, ra = 0, ua = 0, da = 0, hold = 0, pend = 0;
	logic fs = 0, term = 0, cw, cr, ack, ut, dt, rt, req, crst;
	logic [7:0] ca;
	logic [3:0] cb;
	logic [31:0] cd, rdata, rd;
	int fail_count = 0, total_checks = 0, nu, nd, nr, i;
	btc_row_type rows [15] = '{
		'{0, 8'h78, 4'hf, 0, 32'h0000_0010}, '{0, 8'h80, 4'hf, 0, 32'h0010_0010},
		'{0, 8'hb0, 4'hf, 0, 32'h0000_0004}, '{0, 8'hdc, 4'hf, 0, 32'h0001_0b01},
		'{0, 8'he0, 4'hf, 0, 32'h0000_0000}, '{0, 8'he4, 4'hf, 0, 32'h0000_0006},
		'{0, 8'h40, 4'hf, 0, 32'h0000_0000}, '{1, 8'h78, 4'hf, 32'h1234_5678, 32'h1234_5678},
		'{1, 8'h78, 4'hf, 32'h0000_0010, 32'h0000_0010},
		'{1, 8'h80, 4'h3, 32'hffff_0014, 32'h0010_0014},
		'{1, 8'hb0, 4'hf, 32'hffff_ffff, 32'hff3f_0004}, '{1, 8'hdc, 4'hf, '1, 32'h0001_0b01},
		'{1, 8'he0, 4'hf, 32'hffff_ff03, 32'h0000_0003}, '{1, 8'he0, 4'h1, 1, 32'h0000_0003},
		'{1, 8'he0, 4'h1, 2, 32'h0000_0003}};
	always #5 mclk = ~mclk;
	btc_regs #(.RETRY_LIMIT_RESET(32'h0000_0010), .UP_TIMEOUT_RESET(16'h0010),
		.DOWN_TIMEOUT_RESET(16'h0010)) btc_regs_i (.mclk(mclk), .srst(srst), .cfg_write(cw),
		.cfg_read(cr), .cfg_addr(ca), .cfg_byte_en(cb), .cfg_wdata(cd), .cfg_rdata(rdata),
		.cfg_ack(ack), .strap_select_low(sl), .strap_select_high(sh), .retry_active(ra),
		.up_master_active(ua), .down_master_active(da), .retry_timeout(rt),
		.up_master_timeout(ut), .down_master_timeout(dt), .up_hold_request_longer(hold),
		.up_request_pending(pend), .up_frame_start(fs), .up_target_terminate(term),
		.up_bus_request(req), .internal_chip_reset(crst));
	btc_host btc_host_i (.mclk(mclk), .cfg_rdata(rdata), .cfg_ack(ack), .cfg_write(cw),
		.cfg_read(cr), .cfg_addr(ca), .cfg_byte_en(cb), .cfg_wdata(cd));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		if (fail_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	task automatic wait_req(input logic v);
		#1;
		for (int k = 0; k < 8 && req !== v; k++) @(posedge mclk) #1;
		check({31'h0, req}, {31'h0, v});
		if (req !== v) end_of_test();
	endtask : wait_req
	initial begin
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		#1;
		check({26'h0, ack, ut, dt, rt, req, crst}, 0);
		for (i = 0; i < 15; i++) begin
			if (rows[i].w) btc_host_i.access(1'b1, rows[i].a, rows[i].b, rows[i].d, rd);
			btc_host_i.access(1'b0, rows[i].a, 4'hf, 32'h0, rd);
			check(rd, rows[i].e);
		end
		btc_host_i.access(1'b1, btc_pkg::OFS_POWER_CTL, 4'h1, 32'h0, rd);
		check({31'h0, crst}, 1);
		btc_host_i.access(1'b1, btc_pkg::OFS_POWER_CTL, 4'h1, 32'h0, rd);
		check({31'h0, crst}, 0);
		@(posedge mclk);
		{ra, ua, da} <= 3'h7;
		{nu, nd, nr} = 0;
		for (i = 1; i < 40; i++) begin
			@(posedge mclk) #1;
			if (ut === 1'b1 && nu == 0) nu = i;
			if (dt === 1'b1 && nd == 0) nd = i;
			if (rt === 1'b1 && nr == 0) nr = i;
		end
		check(32'(nu >= 20 && nu <= 21), 1);
		check(32'(nd >= 16 && nd <= 17), 1);
		check(32'(nr >= 16 && nr <= 17), 1);
		btc_host_i.access(1'b1, btc_pkg::OFS_RETRY, 4'hf, 32'h0, rd);
		nr = 0;
		for (i = 0; i < 40; i++) begin
			@(posedge mclk) #1;
			if (rt === 1'b1) nr++;
		end
		check(nr, 0);
		@(posedge mclk);
		pend <= 1'b1;
		wait_req(1'b1);
		@(posedge mclk);
		fs <= 1'b1;
		@(posedge mclk);
		fs <= 1'b0;
		wait_req(1'b0);
		@(posedge mclk);
		hold <= 1'b1;
		wait_req(1'b1);
		@(posedge mclk);
		fs <= 1'b1;
		@(posedge mclk);
		fs <= 1'b0;
		repeat (2) @(posedge mclk);
		pend <= 1'b0;
		wait_req(1'b1);
		@(posedge mclk);
		wait_req(1'b0);
		@(posedge mclk);
		pend <= 1'b1;
		wait_req(1'b1);
		@(posedge mclk);
		term <= 1'b1;
		@(posedge mclk);
		term <= 1'b0;
		pend <= 1'b0;
		wait_req(1'b0);
		@(posedge mclk);
		sl <= 1'b0;
		sh <= 1'b1;
		repeat (3) @(posedge mclk);
		btc_host_i.access(1'b0, btc_pkg::OFS_SLOT, 4'hf, 32'h0, rd);
		check({24'h0, rd[15:8]}, 0);
		@(posedge mclk);
		sh <= 1'b0;
		repeat (3) @(posedge mclk);
		btc_host_i.access(1'b0, btc_pkg::OFS_SLOT, 4'hf, 32'h0, rd);
		check({24'h0, rd[15:8]}, 32'h0000_00dc);
		end_of_test();
	end
endmodule : btc_regs_tb
`default_nettype wire
